/* pkg/lh_reset_pkg.sv */
package lh_reset_pkg;

    // Channel count and the two auto-configuring channels
    localparam int NUM_CH = 8;
    localparam int CH_AUTO_A = 4;
    localparam int CH_AUTO_B = 5;

    // Input routing selection per channel (2 bits each)
    localparam logic [1:0] ROUTE_OFF = 2'h0;
    localparam logic [1:0] ROUTE_IN_A = 2'h1;
    localparam logic [1:0] ROUTE_IN_B = 2'h2;
    localparam logic [1:0] ROUTE_ON = 2'h3;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] ROUTE_RESET = 16'h0000;
    localparam logic [7:0] DIAG_RESET = 8'h00;

    // Standard diagnostic frame layout: fault flag, limp-home bit, diag flags
    localparam int FRAME_W = 10;
    localparam int FRAME_FAULT_POS = 9;
    localparam int FRAME_LIMP_POS = 8;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_NORMAL,
        MODE_LIMP
    } mode_t;

    // Host write request carried as one unit
    typedef struct packed {
        logic wr_ctrl;
        logic wr_route;
        logic cmd_reset;
        logic [7:0] ctrl;
        logic [15:0] route;
    } host_req_t;

    // Supply monitor levels
    typedef struct packed {
        logic vbb_ok;
        logic vdd_ok;
    } supply_t;

endpackage : lh_reset_pkg

/* rtl/reset_source.sv */
`timescale 1ns/100ps

// Merges the reset sources into one synchronous hold level
module reset_source
(
    input wire logic mclk_in,                         // System clock
    input wire logic rst_in,                          // Async reset
    input wire lh_reset_pkg::supply_t supply_in,      // Supply monitor levels
    input wire logic cmd_reset_in,                    // Accepted reset command
    input wire logic limp_entry_in,                   // Limp-home entry pulse
    output logic uv_active_out,                       // Undervoltage reset held
    output logic reset_hold_out                       // Any reset this cycle
);

    ////////////////////////////////////////////////////////////////////////////
    // Undervoltage holds until every supply is good
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            uv_active_out <= 1'b1;
        else
            uv_active_out <= !(supply_in.vbb_ok && supply_in.vdd_ok); // R09
    end

    // Command and limp entry are one-cycle resets; undervoltage persists
    always_comb
    begin
        reset_hold_out = uv_active_out || cmd_reset_in || limp_entry_in; // R13
    end

endmodule : reset_source

/* rtl/limp_home_and_reset_control.sv */
`timescale 1ns/100ps

// Function
// R01: Limp-home pin high forces fail-safe mode
// R02: Limp-home entry clears writable configuration registers
// R03: Direct inputs drive channels 4, 5 in limp-home
// R04: Limp-home pin wakes device from standby
// R05: Leaving limp-home always enters sleep mode
// R06: Any reset turns outputs off, loads defaults; limp pin high keeps channels 4, 5 on the direct inputs
// R07: Any reset sets the frame fault flag
// R08: Undervoltage reads return diagnostic frame with fault
// R09: Undervoltage releases only when all supplies good
// R10: Reset command clears configuration and diagnosis
// R11: Limp-home reads show limp bit and diagnosis
// R12: Limp-home ignores every write and command
// R13: Outputs off, defaults held while reset persists; limp pin high keeps channels 4, 5 on the direct inputs
module limp_home_and_reset_control
(
    input wire logic mclk_in,                          // 100 MHz clock
    input wire logic rst_in,                           // Async reset, active high
    input wire logic limp_home_input_in,               // Limp-home pin
    input wire logic direct_control_input_a_in,        // Direct control input A
    input wire logic direct_control_input_b_in,        // Direct control input B
    input wire lh_reset_pkg::supply_t supply_in,       // Supply monitor levels
    input wire logic wake_in,                          // Host wake request
    input wire logic sleep_in,                         // Host sleep request
    input wire lh_reset_pkg::host_req_t host_req_in,   // Host write or command
    input wire logic read_in,                          // Host frame read strobe
    input wire logic [7:0] diag_event_in,              // Diagnosis event pulses
    output logic [7:0] channel_out,                    // Channel on controls
    output logic [lh_reset_pkg::FRAME_W-1:0] frame_out, // Read response frame
    output logic frame_valid_out,                      // Frame valid pulse
    output lh_reset_pkg::mode_t mode_out,              // Current mode
    output logic [7:0] ctrl_out                        // Control register view
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    lh_reset_pkg::mode_t mode_reg;
    lh_reset_pkg::mode_t mode_next;
    logic limp_prev_reg;
    logic limp_entry;
    logic limp_exit;
    logic uv_active;
    logic reset_hold;
    logic cmd_reset;
    logic writes_ok;
    logic [7:0] ctrl_reg;
    logic [15:0] route_reg;
    logic [7:0] diag_reg;
    logic fault_reg;
    logic [7:0] chan_next;

    // Pick one channel's drive from its routing selection
    function automatic logic route_sel(input logic [1:0] sel, input logic a,
                                       input logic b);
        case (sel)
            lh_reset_pkg::ROUTE_IN_A: route_sel = a;
            lh_reset_pkg::ROUTE_IN_B: route_sel = b;
            lh_reset_pkg::ROUTE_ON: route_sel = 1'b1;
            default: route_sel = 1'b0;
        endcase
    endfunction : route_sel

    ////////////////////////////////////////////////////////////////////////////
    // Limp pin edges; inputs are already synchronous
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            limp_prev_reg <= 1'b0;
        else
            limp_prev_reg <= limp_home_input_in;
    end

    assign limp_entry = limp_home_input_in && !limp_prev_reg;
    assign limp_exit = !limp_home_input_in && limp_prev_reg;

    // Host writes count only outside limp-home and undervoltage
    assign writes_ok = !limp_home_input_in && !uv_active; // R12
    assign cmd_reset = host_req_in.cmd_reset && writes_ok; // R10

    reset_source u_reset_source
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .supply_in(supply_in),
        .cmd_reset_in(cmd_reset),
        .limp_entry_in(limp_entry),
        .uv_active_out(uv_active),
        .reset_hold_out(reset_hold)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencing
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            lh_reset_pkg::MODE_SLEEP:
            begin
                if (limp_home_input_in)
                    mode_next = lh_reset_pkg::MODE_LIMP; // R04
                else if (wake_in && !uv_active)
                    mode_next = lh_reset_pkg::MODE_NORMAL;
            end
            lh_reset_pkg::MODE_NORMAL:
            begin
                if (limp_home_input_in)
                    mode_next = lh_reset_pkg::MODE_LIMP; // R01
                else if (sleep_in)
                    mode_next = lh_reset_pkg::MODE_SLEEP;
            end
            lh_reset_pkg::MODE_LIMP:
            begin
                if (!limp_home_input_in)
                    mode_next = lh_reset_pkg::MODE_SLEEP; // R05
            end
            default: mode_next = lh_reset_pkg::MODE_SLEEP;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            mode_reg <= lh_reset_pkg::MODE_SLEEP;
        else
            mode_reg <= mode_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers; limp-home keeps them at default throughout
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl_reg <= lh_reset_pkg::CTRL_RESET;
            route_reg <= lh_reset_pkg::ROUTE_RESET;
        end
        else if (reset_hold || limp_home_input_in)
        begin
            ctrl_reg <= lh_reset_pkg::CTRL_RESET; // R02 R06
            route_reg <= lh_reset_pkg::ROUTE_RESET; // R13
        end
        else if (writes_ok)
        begin
            if (host_req_in.wr_ctrl)
                ctrl_reg <= host_req_in.ctrl;
            if (host_req_in.wr_route)
                route_reg <= host_req_in.route;
        end
    end

    // Diagnosis flags: sticky, cleared by undervoltage or reset command, not limp entry; events still latch in limp
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            diag_reg <= lh_reset_pkg::DIAG_RESET;
        else if (uv_active || cmd_reset)
            diag_reg <= lh_reset_pkg::DIAG_RESET; // R10
        else
            diag_reg <= diag_reg | diag_event_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault flag: set by any reset, cleared once reported; set wins over clear
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            fault_reg <= 1'b1; // R07
        else if (reset_hold)
            fault_reg <= 1'b1; // R07
        else if (read_in)
            fault_reg <= 1'b0;
    end

    // Read response: fault stays set throughout undervoltage
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            frame_out <= '0;
            frame_valid_out <= 1'b0;
        end
        else
        begin
            frame_valid_out <= read_in;
            if (read_in)
            begin
                frame_out[lh_reset_pkg::FRAME_FAULT_POS] <= fault_reg || uv_active; // R08
                frame_out[lh_reset_pkg::FRAME_LIMP_POS] <= limp_home_input_in; // R11
                frame_out[7:0] <= diag_reg; // R11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel drive from routing, limp-home bypass, reset override
    always_comb
    begin
        chan_next = '0;
        for (int i = 0; i < lh_reset_pkg::NUM_CH; i++)
            chan_next[i] = route_sel(route_reg[2*i +: 2], direct_control_input_a_in,
                                     direct_control_input_b_in);
        if (mode_reg != lh_reset_pkg::MODE_NORMAL)
            chan_next = '0;
        if (limp_home_input_in)
        begin
            // Other channels stay off so only the fail-safe loads run
            chan_next = '0;
            chan_next[lh_reset_pkg::CH_AUTO_A] = direct_control_input_a_in; // R03
            chan_next[lh_reset_pkg::CH_AUTO_B] = direct_control_input_b_in; // R03
        end
        else if (reset_hold)
            chan_next = '0; // R06 R13
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            channel_out <= '0;
            mode_out <= lh_reset_pkg::MODE_SLEEP;
            ctrl_out <= lh_reset_pkg::CTRL_RESET;
        end
        else
        begin
            channel_out <= chan_next;
            mode_out <= mode_next;
            ctrl_out <= ctrl_reg;
        end
    end

endmodule : limp_home_and_reset_control

/* sim/lh_reset_monitor.sv */
`timescale 1ns/100ps
// Port-level checks of limp-home and reset behaviour
module lh_reset_monitor
(
    input wire logic mclk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic limp_home_input_in, // Limp pin
    input wire logic direct_control_input_a_in, // Input A
    input wire logic direct_control_input_b_in, // Input B
    input wire lh_reset_pkg::supply_t supply_in, // Supplies
    input wire lh_reset_pkg::host_req_t host_req_in, // Host request
    input wire logic read_in, // Read strobe
    input wire logic [7:0] channel_out, // Channels
    input wire logic [lh_reset_pkg::FRAME_W-1:0] frame_out, // Frame
    input wire logic frame_valid_out, // Frame valid
    input wire lh_reset_pkg::mode_t mode_out, // Mode
    input wire logic [7:0] ctrl_out // Control view
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Limp-home entry, routing, exit
    a_limp_mode:
        assert property (limp_home_input_in |=> mode_out == lh_reset_pkg::MODE_LIMP)
        else $error("mode not limp");
    a_limp_clear:
        assert property (limp_home_input_in [*4] |-> ctrl_out == 8'h00)
        else $error("ctrl kept in limp");
    a_limp_route:
        assert property (limp_home_input_in && $past(limp_home_input_in) |=> channel_out
            == {2'h0, $past(direct_control_input_b_in), $past(direct_control_input_a_in), 4'h0})
        else $error("limp channels wrong");
    a_limp_exit:
        assert property ($fell(limp_home_input_in) |=>
            mode_out == lh_reset_pkg::MODE_SLEEP && channel_out == 8'h00)
        else $error("limp exit not sleep");
    // Read path; undervoltage needs a settled low supply since the flag is registered
    a_read_limp:
        assert property (read_in |=> frame_valid_out && frame_out[8] == $past(limp_home_input_in))
        else $error("read frame wrong");
    a_uv_fault:
        assert property (read_in && !(&supply_in) && !(&$past(supply_in)) |=> frame_out[9])
        else $error("uv read without fault");
    a_uv_off:
        assert property ((!(&supply_in)) [*2] |=> channel_out == 8'h00)
        else $error("channels on in uv");
    a_cmd_clear:
        assert property (host_req_in.cmd_reset && !limp_home_input_in |=>
            channel_out == 8'h00 ##1 ctrl_out == 8'h00)
        else $error("command reset ignored");
endmodule : lh_reset_monitor

bind limp_home_and_reset_control lh_reset_monitor u_lh_reset_monitor (.mclk_in, .rst_in,
    .limp_home_input_in, .direct_control_input_a_in, .direct_control_input_b_in, .supply_in,
    .host_req_in, .read_in, .channel_out, .frame_out, .frame_valid_out, .mode_out, .ctrl_out);

/* sim/host_model.sv */
`timescale 1ns/100ps
// Host side; strobes last one cycle, data is inverted once released
module host_model
(
    input wire logic mclk_in, // Clock
    output lh_reset_pkg::host_req_t req_out, // Request
    output logic read_out, // Read
    output logic wake_out, // Wake
    output logic sleep_out // Sleep
);
    initial {req_out, read_out, wake_out, sleep_out} = '0;
    // Drive at a falling edge, release after the taking edge
    task automatic pulse(input lh_reset_pkg::host_req_t r, input logic [2:0] s);
        @(negedge mclk_in);
        {req_out, read_out, wake_out, sleep_out} = {r, s};
        @(negedge mclk_in);
        {req_out, read_out, wake_out, sleep_out} = {3'h0, ~r[23:0], 3'h0};
    endtask : pulse
endmodule : host_model

/* sim/tb_limp_home_and_reset_control.sv */
`timescale 1ns/100ps
// Scenario bench for limp-home and reset control
module tb_limp_home_and_reset_control;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic limp = 1'b0;
    logic in_a = 1'b0;
    logic in_b = 1'b0;
    lh_reset_pkg::supply_t supply = 2'h3;
    logic [7:0] diag = 8'h00;
    lh_reset_pkg::host_req_t req;
    logic rd, wk, sl, valid;
    logic [7:0] chan, ctrl;
    logic [9:0] frame;
    lh_reset_pkg::mode_t mode;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    limp_home_and_reset_control u_limp_home_and_reset_control (.mclk_in(mclk_in),
        .rst_in(rst_in), .limp_home_input_in(limp), .direct_control_input_a_in(in_a),
        .direct_control_input_b_in(in_b), .supply_in(supply), .wake_in(wk), .sleep_in(sl),
        .host_req_in(req), .read_in(rd), .diag_event_in(diag), .channel_out(chan),
        .frame_out(frame), .frame_valid_out(valid), .mode_out(mode), .ctrl_out(ctrl));
    host_model u_host_model (.mclk_in(mclk_in), .req_out(req), .read_out(rd),
        .wake_out(wk), .sleep_out(sl));
    initial forever #5 mclk_in = ~mclk_in;
    // Hang guard, well above the scenario length
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] c, input logic [15:0] r);
        u_host_model.pulse({3'h6, c, r}, 3'h0);
        @(negedge mclk_in);
    endtask : wr
    task automatic t_reset();
        u_host_model.pulse('0, 3'h4);
        chk({valid, frame}, 11'h600);
        chk({mode, chan, ctrl}, {lh_reset_pkg::MODE_SLEEP, 16'h0});
        u_host_model.pulse('0, 3'h4);
        chk(frame, 10'h000);
    endtask : t_reset
    // Command reset after a live configuration
    task automatic t_cmd();
        u_host_model.pulse('0, 3'h2);
        in_a = 1'b1;
        wr(8'ha5, 16'h0327);
        chk({chan, ctrl}, 16'h13a5);
        u_host_model.pulse({3'h1, 24'h0}, 3'h0);
        @(negedge mclk_in);
        chk({chan, ctrl}, 16'h0000);
        u_host_model.pulse('0, 3'h4);
        chk(frame[9], 1'b1);
    endtask : t_cmd
    // Limp from standby; writes and commands must not land
    task automatic t_limp();
        u_host_model.pulse('0, 3'h2);
        wr(8'h3c, 16'h0327);
        u_host_model.pulse('0, 3'h1);
        limp = 1'b1;
        diag = 8'h21;
        @(negedge mclk_in);
        diag = 8'h00;
        repeat (3) @(negedge mclk_in);
        chk({mode, chan, ctrl}, {lh_reset_pkg::MODE_LIMP, 16'h1000});
        wr(8'hff, 16'hffff);
        u_host_model.pulse({3'h1, 24'h0}, 3'h0);
        @(negedge mclk_in);
        chk(ctrl, 8'h00);
        u_host_model.pulse('0, 3'h4);
        chk(frame, 10'h321);
        {in_a, in_b} = 2'h1;
        repeat (2) @(negedge mclk_in);
        chk(chan, 8'h20);
        limp = 1'b0;
        repeat (2) @(negedge mclk_in);
        chk({mode, chan}, {lh_reset_pkg::MODE_SLEEP, 8'h00});
        // Second episode from normal mode, so a return to the old mode would show
        u_host_model.pulse('0, 3'h2);
        limp = 1'b1;
        repeat (2) @(negedge mclk_in);
        chk(mode, lh_reset_pkg::MODE_LIMP);
        limp = 1'b0;
        repeat (2) @(negedge mclk_in);
        chk({mode, chan}, {lh_reset_pkg::MODE_SLEEP, 8'h00});
    endtask : t_limp
    // Logic supply drop, then recovery
    task automatic t_uv();
        u_host_model.pulse('0, 3'h2);
        wr(8'h3c, 16'h0003);
        supply = 2'h2;
        repeat (2) @(negedge mclk_in);
        chk(chan, 8'h00);
        wr(8'h11, 16'h0003);
        u_host_model.pulse('0, 3'h4);
        chk({frame[9], ctrl}, 9'h100);
        // Logic supply back but power supply low: the reset must still hold
        supply = 2'h1;
        repeat (2) @(negedge mclk_in);
        wr(8'h5a, 16'h0000);
        chk(ctrl, 8'h00);
        supply = 2'h3;
        repeat (3) @(negedge mclk_in);
        u_host_model.pulse('0, 3'h2);
        wr(8'h5a, 16'h0000);
        chk(ctrl, 8'h5a);
    endtask : t_uv
    task automatic wrap_up();
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (6) @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        t_reset();
        t_cmd();
        t_limp();
        t_uv();
        wrap_up();
    end
endmodule : tb_limp_home_and_reset_control
